// ### flash_code_write_protection.sv
`timescale 1ns/1ps
`include "flash_protect_consts.svh"

module flash_code_write_protection
  import flash_protect_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic rstn_in,
  // Programmer command port
  input wire logic prog_valid_in,
  input wire prog_req_s prog_req_in,
  input wire logic low_level_mode_in,
  output logic prog_ready_out,
  output logic prog_done_out,
  output logic prog_refused_out,
  output refuse_cause_e prog_cause_out,
  output logic prog_rvalid_out,
  output logic [`WORD_W-1:0] prog_rdata_out,
  // Program memory array
  output logic flash_wr_out,
  output logic flash_erase_all_out,
  output logic [`ADDR_W-1:0] flash_addr_out,
  output logic [`WORD_W-1:0] flash_wdata_out,
  input wire logic [`WORD_W-1:0] flash_rdata_in,
  // Internal write and erase requests
  input wire nvm_req_s nvm_req_in,
  output logic nvm_interlock_en_out,
  output logic nvm_reject_out,
  output nvm_cause_s nvm_cause_out,
  // Protection status
  output logic general_code_protect_out,
  output logic general_write_protect_out,
  output logic segment_active_out,
  output logic [`PAGE_W-1:0] seg_lo_page_out,
  output logic [`PAGE_W-1:0] seg_hi_page_out,
  output logic [`CNT_W-1:0] cfg_words_written_out,
  output logic cfg_set_complete_out
);

  // Stored configuration words
  logic [`CFG_WORDS-1:0][`WORD_W-1:0] cfg_words;
  logic [`WORD_W-1:0] cw1;
  logic [`WORD_W-1:0] cw3;

  // Command capture
  prog_state_e state_reg;
  prog_state_e state_next;
  prog_req_s req_reg;
  logic take;

  // Command decode of the held request
  logic req_is_cfg;
  logic [`CFG_IDX_W-1:0] req_idx;
  logic [`WORD_W-1:0] req_old;
  logic [`WORD_W-1:0] req_lock_mask;
  logic [`WORD_W-1:0] req_merged;
  logic code_protect;
  logic write_protect;
  logic exec;
  logic do_cfg_write;
  logic do_flash_write;
  logic do_erase;
  logic do_read;
  logic refuse;
  refuse_cause_e cause;

  // Internal request checking
  seg_decode_s seg;
  logic nvm_out_of_range;
  nvm_cause_s nvm_cause;
  logic nvm_reject;

  // Written-word bookkeeping
  logic [`CFG_WORDS-1:0] written_mask_reg;
  logic [`CNT_W-1:0] written_cnt;

  assign cw1 = cfg_words[`CW1_IDX];
  assign cw3 = cfg_words[`CW3_IDX];
  assign code_protect = ~cw1[`CW1_GCP_BIT];
  assign write_protect = ~cw1[`CW1_GENERAL_WRITE_PROTECT_BIT];

  config_word_bank u_bank (
    .sys_clk_in(sys_clk_in),
    .rstn_in(rstn_in),
    .wr_en_in(do_cfg_write),
    .wr_idx_in(req_idx),
    .wr_data_in(req_merged),
    .erase_all_in(do_erase),
    .words_out(cfg_words)
  );

  segment_range_check u_seg (
    .cw3_in(cw3),
    .addr_in(nvm_req_in.addr),
    .seg_out(seg)
  );

  // One command at a time; the port is busy for the execute cycle
  assign prog_ready_out = (state_reg == ST_IDLE);
  assign take = prog_valid_in && prog_ready_out;
  assign exec = (state_reg == ST_EXEC);

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (take) begin
          state_next = ST_EXEC;
        end
      end
      ST_EXEC: begin
        state_next = ST_IDLE;
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      req_reg <= '0;
    end else if (take) begin
      req_reg <= prog_req_in;
    end
  end

  // Config words sit as consecutive even addresses on the last page
  localparam logic [`ADDR_W-1:0] cfg_base = `CFG_BASE;
  assign req_is_cfg =
    req_reg.addr[`ADDR_W-1:`CFG_TAG_LSB] ==
    cfg_base[`ADDR_W-1:`CFG_TAG_LSB] && !req_reg.addr[0];
  assign req_idx = req_reg.addr[`CFG_IDX_MSB:`CFG_IDX_LSB];
  assign req_old = cfg_words[req_idx];

  // Code-protect, write-protect and segment-disable bits may only be programmed towards the active state
  always_comb begin
    case (req_idx)
      `CW1_IDX: begin
        req_lock_mask = `CW1_LOCK_MASK;
      end
      `CW3_IDX: begin
        req_lock_mask = `CW3_LOCK_MASK;
      end
      default: begin
        req_lock_mask = '0;
      end
    endcase
  end

  assign req_merged = (req_reg.data & ~req_lock_mask)
    | (req_reg.data & req_old & req_lock_mask);

  // Execute-cycle decision for the held programmer command
  always_comb begin
    do_cfg_write = 1'b0;
    do_flash_write = 1'b0;
    do_erase = 1'b0;
    do_read = 1'b0;
    refuse = 1'b0;
    cause = CAUSE_NONE;
    if (exec) begin
      case (req_reg.cmd)
        CMD_WORD_PROGRAM: begin
          if (req_is_cfg) begin
            // One word per command; lock bits only clear
            do_cfg_write = 1'b1;
          end else if (code_protect) begin
            refuse = 1'b1;
            cause = CAUSE_READ_PROTECT;
          end else begin
            do_flash_write = 1'b1;
          end
        end
        CMD_READ_PROGRAM: begin
          // Config words stay readable so the write can be verified
          if (!req_is_cfg && code_protect) begin
            refuse = 1'b1;
            cause = CAUSE_READ_PROTECT;
          end else begin
            do_read = 1'b1;
          end
        end
        CMD_CHIP_ERASE: begin
          if (low_level_mode_in) begin
            do_erase = 1'b1;
          end else begin
            refuse = 1'b1;
            cause = CAUSE_MODE;
          end
        end
        CMD_NOP: begin
          do_read = 1'b0;
        end
        default: begin
          refuse = 1'b1;
          cause = CAUSE_ADDRESS;
        end
      endcase
    end
  end

  // Answer pulses, one cycle after the execute cycle starts
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      prog_done_out <= 1'b0;
      prog_refused_out <= 1'b0;
      prog_rvalid_out <= 1'b0;
    end else begin
      prog_done_out <= exec && !refuse;
      prog_refused_out <= refuse;
      prog_rvalid_out <= do_read;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      prog_cause_out <= CAUSE_NONE;
    end else if (exec) begin
      prog_cause_out <= cause;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      prog_rdata_out <= '0;
    end else if (do_read) begin
      prog_rdata_out <= req_is_cfg ? req_old : flash_rdata_in;
    end
  end

  // Program memory strobes; the array reads asynchronously
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      flash_wr_out <= 1'b0;
      flash_erase_all_out <= 1'b0;
    end else begin
      flash_wr_out <= do_flash_write;
      flash_erase_all_out <= do_erase;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      flash_addr_out <= '0;
      flash_wdata_out <= '0;
    end else if (take) begin
      flash_addr_out <= prog_req_in.addr;
      flash_wdata_out <= prog_req_in.data;
    end
  end

  // Which config words have been written since the last erase
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      written_mask_reg <= '0;
    end else if (do_erase) begin
      written_mask_reg <= '0;
    end else if (do_cfg_write) begin
      written_mask_reg[req_idx] <= 1'b1;
    end
  end

  always_comb begin
    written_cnt = '0;
    for (int i = 0; i < `CFG_WORDS; i++) begin
      written_cnt = written_cnt + {{(`CNT_W-1){1'b0}}, written_mask_reg[i]};
    end
  end

  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cfg_words_written_out <= '0;
      cfg_set_complete_out <= 1'b0;
    end else begin
      cfg_words_written_out <= written_cnt;
      cfg_set_complete_out <= (written_cnt == `CNT_FULL);
    end
  end

  // Internal write and erase check, decided in the request's own cycle
  assign nvm_out_of_range =
    nvm_req_in.addr[`ADDR_W-1:`PAGE_LSB] >
    {{(`ADDR_W-1-`PAGE_MSB){1'b0}}, `LAST_PAGE};

  always_comb begin
    nvm_cause.general = write_protect;
    nvm_cause.segment = seg.in_segment;
    nvm_cause.config_page = seg.config_hit;
    nvm_cause.range = nvm_out_of_range;
  end

  // Segment terms only add rejects; general lock applies everywhere
  assign nvm_reject = nvm_req_in.valid && (nvm_cause.general
    || nvm_cause.segment || nvm_cause.config_page
    || nvm_cause.range);

  assign nvm_reject_out = nvm_reject;
  assign nvm_interlock_en_out = nvm_req_in.valid && !nvm_reject;
  assign nvm_cause_out = nvm_req_in.valid ? nvm_cause : '0;

  // Status mirrors lag the stored words by one cycle
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      general_code_protect_out <= 1'b0;
      general_write_protect_out <= 1'b0;
      segment_active_out <= 1'b0;
    end else begin
      general_code_protect_out <= code_protect;
      general_write_protect_out <= write_protect;
      segment_active_out <= ~cw3[`CW3_SEG_DIS_BIT];
    end
  end

  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      seg_lo_page_out <= '0;
      seg_hi_page_out <= '0;
    end else begin
      seg_lo_page_out <= seg.lo_page;
      seg_hi_page_out <= seg.hi_page;
    end
  end

endmodule : flash_code_write_protection

// ### flash_protect_consts.svh
// Notes on behaviour
// - End-select 0: pages 0 up to and including segment page are locked.
// - End-select 1: segment page through last user page are locked.
// - Segment disable 1 turns segment locking off; 0 turns it on.
// - Config-page protect 0 with segment on locks last page and config words.
// - With segment on, end-select 1 or segment page on config page locks config page.
// - Code-protect active blocks programmer reads and writes of non-config addresses, not execution.
// - General write-protect at 0 blocks every internal write and erase.
// - A write or erase inside the protected segment drops the interlock.
// - Segment locking adds to general protection and never relaxes it.
// - Code-protect bits return from 0 to 1 only by low-level chip erase.
`ifndef FLASH_PROTECT_CONSTS_SVH
`define FLASH_PROTECT_CONSTS_SVH

`define ADDR_W 24
`define WORD_W 24
`define PAGE_W 7
`define PAGE_LSB 11
`define PAGE_MSB 17
`define LAST_PAGE 7'h55
`define CFG_BASE 24'h02aff8
`define CFG_WORDS 4
`define CFG_IDX_W 2
`define CFG_IDX_LSB 1
`define CFG_IDX_MSB 2
`define CFG_TAG_LSB 3
`define ERASED_WORD 24'hffffff
`define CW1_IDX 2'h0
`define CW3_IDX 2'h2
`define CW1_GCP_BIT 13
`define CW1_GENERAL_WRITE_PROTECT_BIT 12
`define CW1_LOCK_MASK 24'h003000
`define CW3_LOCK_MASK 24'h002000
`define CW3_END_SEL_BIT 15
`define CW3_CFG_PROT_BIT 14
`define CW3_SEG_DIS_BIT 13
`define CW3_PAGE_MSB 6
`define CW3_PAGE_LSB 0
`define CNT_W 3
`define CNT_FULL 3'h4
`define CNT_ONE 3'h1

`endif

// ### flash_protect_pkg.sv
`include "flash_protect_consts.svh"

package flash_protect_pkg;

  typedef enum logic [1:0] {
    CMD_NOP = 2'b00,
    CMD_WORD_PROGRAM = 2'b01,
    CMD_READ_PROGRAM = 2'b10,
    CMD_CHIP_ERASE = 2'b11
  } prog_cmd_e;

  typedef enum logic [1:0] {
    CAUSE_NONE = 2'b00,
    CAUSE_READ_PROTECT = 2'b01,
    CAUSE_MODE = 2'b10,
    CAUSE_ADDRESS = 2'b11
  } refuse_cause_e;

  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_EXEC = 1'b1
  } prog_state_e;

  typedef struct packed {
    prog_cmd_e cmd;
    logic [`ADDR_W-1:0] addr;
    logic [`WORD_W-1:0] data;
  } prog_req_s;

  typedef struct packed {
    logic valid;
    logic erase;
    logic [`ADDR_W-1:0] addr;
  } nvm_req_s;

  typedef struct packed {
    logic general;
    logic segment;
    logic config_page;
    logic range;
  } nvm_cause_s;

  typedef struct packed {
    logic active;
    logic in_segment;
    logic config_hit;
    logic [`PAGE_W-1:0] lo_page;
    logic [`PAGE_W-1:0] hi_page;
  } seg_decode_s;

endpackage : flash_protect_pkg

// ### config_word_bank.sv
`timescale 1ns/1ps
`include "flash_protect_consts.svh"

module config_word_bank
  import flash_protect_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic rstn_in,
  // Update port
  input wire logic wr_en_in,
  input wire logic [`CFG_IDX_W-1:0] wr_idx_in,
  input wire logic [`WORD_W-1:0] wr_data_in,
  input wire logic erase_all_in,
  // Stored words
  output logic [`CFG_WORDS-1:0][`WORD_W-1:0] words_out
);

  // Reset stands for the erased array; real cells keep their value
  genvar gi;
  generate
    for (gi = 0; gi < `CFG_WORDS; gi++) begin : g_word
      logic [`WORD_W-1:0] word_reg;
      always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
          word_reg <= `ERASED_WORD;
        end else if (erase_all_in) begin
          word_reg <= `ERASED_WORD;
        end else if (wr_en_in && wr_idx_in == `CFG_IDX_W'(gi)) begin
          word_reg <= wr_data_in;
        end
      end
      assign words_out[gi] = word_reg;
    end
  endgenerate

endmodule : config_word_bank

// ### segment_range_check.sv
`timescale 1ns/1ps
`include "flash_protect_consts.svh"

module segment_range_check
  import flash_protect_pkg::*;
(
  // Segment settings
  input wire logic [`WORD_W-1:0] cw3_in,
  // Target of a write or erase
  input wire logic [`ADDR_W-1:0] addr_in,
  // Decode
  output seg_decode_s seg_out
);

  logic [`PAGE_W-1:0] page;
  logic [`PAGE_W-1:0] seg_page;
  logic end_sel;

  assign page = addr_in[`PAGE_MSB:`PAGE_LSB];
  assign seg_page = cw3_in[`CW3_PAGE_MSB:`CW3_PAGE_LSB];
  assign end_sel = cw3_in[`CW3_END_SEL_BIT];

  always_comb begin
    seg_out.active = ~cw3_in[`CW3_SEG_DIS_BIT];
    seg_out.lo_page = end_sel ? seg_page : '0;
    seg_out.hi_page = end_sel ? `LAST_PAGE : seg_page;
    seg_out.in_segment = seg_out.active &&
      page >= seg_out.lo_page && page <= seg_out.hi_page;
    // Config words share the last page, so both hit on that page
    seg_out.config_hit = seg_out.active && page == `LAST_PAGE &&
      (~cw3_in[`CW3_CFG_PROT_BIT]
       || end_sel || seg_page == `LAST_PAGE);
  end

endmodule : segment_range_check

// ### flash_code_write_protection_monitor.sv
`timescale 1ns/1ps
`include "flash_protect_consts.svh"

module flash_code_write_protection_monitor
  import flash_protect_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic rstn_in,
  // Programmer port
  input wire logic prog_valid_in,
  input wire prog_req_s prog_req_in,
  input wire logic low_level_mode_in,
  input wire logic prog_ready_out,
  input wire logic prog_done_out,
  input wire logic prog_refused_out,
  input wire refuse_cause_e prog_cause_out,
  input wire logic flash_erase_all_out,
  // Internal requests
  input wire nvm_req_s nvm_req_in,
  input wire logic nvm_interlock_en_out,
  input wire logic nvm_reject_out,
  input wire nvm_cause_s nvm_cause_out,
  // Status
  input wire logic general_code_protect_out,
  input wire logic general_write_protect_out,
  input wire logic segment_active_out,
  input wire logic [`PAGE_W-1:0] seg_lo_page_out,
  input wire logic [`PAGE_W-1:0] seg_hi_page_out,
  input wire logic [`CNT_W-1:0] cfg_words_written_out
);
  logic take;
  logic is_cfg;
  logic [`PAGE_W-1:0] page;
  assign take = prog_valid_in && prog_ready_out;
  assign is_cfg = {prog_req_in.addr[23:3], 3'h0} == `CFG_BASE &&
    !prog_req_in.addr[0];
  assign page = nvm_req_in.addr[`PAGE_MSB:`PAGE_LSB];

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rstn_in);

  // Status lags the stored words while a finished command is answered
  reject_excludes_a: assert property (nvm_reject_out |->
    nvm_req_in.valid && !nvm_interlock_en_out) else $error("bad reject");
  one_verdict_a: assert property (nvm_req_in.valid |->
    nvm_interlock_en_out != nvm_reject_out) else $error("no verdict");
  cause_idle_a: assert property (!nvm_req_in.valid |->
    nvm_cause_out == '0) else $error("cause while idle");
  general_wp_a: assert property (nvm_req_in.valid &&
    general_write_protect_out && !prog_done_out |->
    nvm_reject_out && nvm_cause_out.general) else $error("gwp missed");
  segment_range_a: assert property (nvm_req_in.valid &&
    segment_active_out && !prog_done_out && page >= seg_lo_page_out &&
    page <= seg_hi_page_out |-> nvm_reject_out) else $error("seg missed");
  answer_time_a: assert property (take |=> !prog_ready_out ##1
    prog_ready_out && (prog_done_out != prog_refused_out))
    else $error("answer late");
  external_block_a: assert property (take && !is_cfg &&
    prog_req_in.cmd inside {CMD_WORD_PROGRAM, CMD_READ_PROGRAM} &&
    general_code_protect_out && !prog_done_out |-> ##2 prog_refused_out &&
    prog_cause_out == CAUSE_READ_PROTECT) else $error("read not blocked");
  erase_mode_a: assert property (take &&
    prog_req_in.cmd == CMD_CHIP_ERASE ##1 !low_level_mode_in |=>
    prog_refused_out && !flash_erase_all_out &&
    prog_cause_out == CAUSE_MODE) else $error("erase outside mode");
  erase_clears_a: assert property (take &&
    prog_req_in.cmd == CMD_CHIP_ERASE ##1 low_level_mode_in |=>
    flash_erase_all_out && prog_done_out ##1 !general_code_protect_out &&
    !general_write_protect_out && !segment_active_out &&
    cfg_words_written_out == '0) else $error("erase incomplete");

  cover property (take && prog_req_in.cmd == CMD_CHIP_ERASE);
  cover property (nvm_reject_out && nvm_cause_out.segment);
  cover property (prog_refused_out && prog_cause_out == CAUSE_READ_PROTECT);
endmodule : flash_code_write_protection_monitor

bind flash_code_write_protection flash_code_write_protection_monitor
  u_flash_code_write_protection_monitor (.sys_clk_in, .rstn_in,
  .prog_valid_in, .prog_req_in, .low_level_mode_in, .prog_ready_out,
  .prog_done_out, .prog_refused_out, .prog_cause_out, .flash_erase_all_out,
  .nvm_req_in, .nvm_interlock_en_out, .nvm_reject_out, .nvm_cause_out,
  .general_code_protect_out, .general_write_protect_out,
  .segment_active_out, .seg_lo_page_out, .seg_hi_page_out,
  .cfg_words_written_out);

// ### prog_host_model.sv
`timescale 1ns/1ps
`include "flash_protect_consts.svh"

module prog_host_model
  import flash_protect_pkg::*;
(
  // Clock
  input wire logic sys_clk_in,
  // Answers from the device
  input wire logic prog_ready_out,
  input wire logic prog_done_out,
  input wire logic prog_refused_out,
  input wire refuse_cause_e prog_cause_out,
  input wire logic [`WORD_W-1:0] prog_rdata_out,
  // Requests to the device
  output logic prog_valid_out,
  output prog_req_s prog_req_out
);
  initial begin
    prog_valid_out = 1'b0;
    prog_req_out = '0;
  end

  task automatic run(input prog_cmd_e cmd, input logic [`ADDR_W-1:0] addr,
    input logic [`WORD_W-1:0] data, output logic done,
    output logic [`WORD_W-1:0] rdata, output refuse_cause_e cause);
    int n;
    n = 0;
    @(negedge sys_clk_in);
    prog_valid_out = 1'b1;
    prog_req_out = '{cmd: cmd, addr: addr, data: data};
    // Ready is settled at the falling edge; the next rising edge takes it
    while (!prog_ready_out && n < 8) begin
      n++;
      @(negedge sys_clk_in);
    end
    @(negedge sys_clk_in);
    prog_valid_out = 1'b0;
    // Released lines carry the inverse so a stale value cannot pass
    prog_req_out = ~prog_req_out;
    n = 0;
    while (!(prog_done_out || prog_refused_out) && n < 4) begin
      n++;
      @(negedge sys_clk_in);
    end
    done = prog_done_out;
    rdata = prog_rdata_out;
    cause = prog_cause_out;
    @(negedge sys_clk_in);
  endtask : run
endmodule : prog_host_model

// ### flash_code_write_protection_tb.sv
`timescale 1ns/1ps
`include "flash_protect_consts.svh"

module flash_code_write_protection_tb;
  import flash_protect_pkg::*;
  logic sys_clk_in = 1'b0;
  logic rstn_in = 1'b0;
  logic prog_valid_in, low_level_mode_in = 1'b0;
  prog_req_s prog_req_in;
  logic prog_ready_out, prog_done_out, prog_refused_out, prog_rvalid_out;
  refuse_cause_e prog_cause_out;
  logic [23:0] prog_rdata_out, flash_addr_out, rd, wdata;
  logic flash_wr_out, flash_erase_all_out, general_code_protect, gwp, seg_on, complete;
  logic nvm_interlock_en_out, nvm_reject_out;
  nvm_req_s nvm_req_in = '0;
  nvm_cause_s nvm_cause_out;
  logic [6:0] lo, hi;
  logic [2:0] written;
  int fails = 0;
  int comparisons = 0;
  int reads = 0;
  int writes = 0;
  int erases = 0;

  initial forever #20 sys_clk_in = ~sys_clk_in;

  flash_code_write_protection u_flash_code_write_protection (.sys_clk_in,
    .rstn_in, .prog_valid_in, .prog_req_in, .low_level_mode_in,
    .prog_ready_out, .prog_done_out, .prog_refused_out, .prog_cause_out,
    .prog_rvalid_out, .prog_rdata_out, .flash_wr_out, .flash_erase_all_out,
    .flash_addr_out, .flash_wdata_out(wdata),
    .flash_rdata_in(flash_addr_out ^ 24'h5a5a5a), .nvm_req_in,
    .nvm_interlock_en_out, .nvm_reject_out, .nvm_cause_out,
    .general_code_protect_out(general_code_protect), .general_write_protect_out(gwp),
    .segment_active_out(seg_on), .seg_lo_page_out(lo), .seg_hi_page_out(hi),
    .cfg_words_written_out(written), .cfg_set_complete_out(complete));

  prog_host_model u_prog_host_model (.sys_clk_in, .prog_ready_out,
    .prog_done_out, .prog_refused_out, .prog_cause_out, .prog_rdata_out,
    .prog_valid_out(prog_valid_in), .prog_req_out(prog_req_in));

  // Pulses are counted at the edge that ends them
  always @(posedge sys_clk_in) begin
    if (prog_rvalid_out) reads++;
    if (flash_wr_out) writes++;
    if (flash_erase_all_out) erases++;
  end

  task automatic stop_test();
    if (fails == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : stop_test

  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  function automatic logic [23:0] pg(input logic [6:0] p);
    return {6'h0, p, 11'h0};
  endfunction : pg

  task automatic cmd(input prog_cmd_e c, input logic [23:0] a, d,
    input logic ok, input refuse_cause_e cz);
    logic done;
    refuse_cause_e cause;
    int r0;
    r0 = reads;
    u_prog_host_model.run(c, a, d, done, rd, cause);
    check({23'h0, done}, {23'h0, ok});
    if (!ok) check({22'h0, cause}, {22'h0, cz});
    check(24'(reads - r0), {23'h0, ok && c == CMD_READ_PROGRAM});
  endtask : cmd

  task automatic wcfg(input logic [1:0] i, input logic [23:0] d);
    cmd(CMD_WORD_PROGRAM, `CFG_BASE + {21'h0, i, 1'b0}, d, 1'b1, CAUSE_NONE);
  endtask : wcfg

  task automatic rcfg(input logic [1:0] i, input logic [23:0] exp);
    cmd(CMD_READ_PROGRAM, `CFG_BASE + {21'h0, i, 1'b0}, '0, 1'b1, CAUSE_NONE);
    check(rd, exp);
  endtask : rcfg

  task automatic nvm(input logic [23:0] a, input logic rej,
    input logic [3:0] cm);
    @(negedge sys_clk_in);
    nvm_req_in = '{valid: 1'b1, erase: a[11], addr: a};
    #1;
    check({23'h0, nvm_reject_out}, {23'h0, rej});
    check({23'h0, nvm_interlock_en_out}, {23'h0, !rej});
    check({20'h0, nvm_cause_out & cm}, {20'h0, cm});
    // Hold the request over a rising edge so the monitor sees it
    @(negedge sys_clk_in);
    nvm_req_in = '{valid: 1'b0, erase: 1'b0, addr: ~a};
  endtask : nvm

  task automatic t_reset();
    check({20'h0, prog_ready_out, general_code_protect, gwp, seg_on}, 24'h8);
    check({21'h0, written}, 24'h0);
  endtask : t_reset

  task automatic t_open();
    cmd(CMD_NOP, '0, '0, 1'b1, CAUSE_NONE);
    nvm(pg(7'h00), 1'b0, 4'h0);
    nvm(pg(7'h55), 1'b0, 4'h0);
    nvm(pg(7'h56), 1'b1, 4'h1);
  endtask : t_open

  task automatic t_cfg();
    for (int i = 0; i < 4; i++) begin
      wcfg(i[1:0], 24'h00ffff);
    end
    check({20'h0, complete, written}, 24'hc);
    for (int i = 0; i < 4; i++) rcfg(i[1:0], 24'h00ffff);
  endtask : t_cfg

  task automatic t_segment();
    wcfg(2'h2, 24'h005f90);
    check({9'h0, seg_on, lo, hi}, {9'h1, 7'h00, 7'h10});
    nvm(pg(7'h00), 1'b1, 4'h4);
    nvm(pg(7'h10), 1'b1, 4'h4);
    nvm(pg(7'h11), 1'b0, 4'h0);
    wcfg(2'h2, 24'h00dfa0);
    check({10'h0, lo, hi}, {10'h0, 7'h20, 7'h55});
    nvm(pg(7'h1f), 1'b0, 4'h0);
    nvm(pg(7'h20), 1'b1, 4'h4);
    nvm(pg(7'h55), 1'b1, 4'h0);
    wcfg(2'h2, 24'h001f90);
    nvm(pg(7'h55), 1'b1, 4'h2);
    nvm(pg(7'h30), 1'b0, 4'h0);
    wcfg(2'h2, 24'h005fd5);
    nvm(pg(7'h55), 1'b1, 4'h0);
    nvm(pg(7'h54), 1'b1, 4'h4);
    wcfg(2'h2, 24'h00ffff);
    rcfg(2'h2, 24'h00dfff);
  endtask : t_segment

  task automatic t_general();
    cmd(CMD_READ_PROGRAM, 24'h000100, '0, 1'b1, CAUSE_NONE);
    check(rd, 24'h000100 ^ 24'h5a5a5a);
    cmd(CMD_WORD_PROGRAM, 24'h000100, 24'h00a5c3, 1'b1,
      CAUSE_NONE);
    check(24'(writes), 24'h1);
    check(wdata, 24'h00a5c3);
    check(flash_addr_out, 24'h000100);
    wcfg(2'h0, 24'h00efff);
    check({23'h0, gwp}, 24'h1);
    nvm(pg(7'h30), 1'b1, 4'h8);
    nvm(pg(7'h00), 1'b1, 4'h8);
    wcfg(2'h0, 24'h00cfff);
    check({23'h0, general_code_protect}, 24'h1);
    cmd(CMD_READ_PROGRAM, 24'h000100, '0, 1'b0,
      CAUSE_READ_PROTECT);
    cmd(CMD_WORD_PROGRAM, 24'h000100, 24'h00a5c3, 1'b0,
      CAUSE_READ_PROTECT);
    check(24'(writes), 24'h1);
    wcfg(2'h0, 24'h00ffff);
    rcfg(2'h0, 24'h00cfff);
  endtask : t_general

  task automatic t_erase();
    low_level_mode_in = 1'b0;
    cmd(CMD_CHIP_ERASE, '0, '0, 1'b0, CAUSE_MODE);
    check(24'(erases), 24'h0);
    rcfg(2'h0, 24'h00cfff);
    low_level_mode_in = 1'b1;
    cmd(CMD_CHIP_ERASE, '0, '0, 1'b1, CAUSE_NONE);
    low_level_mode_in = 1'b0;
    check(24'(erases), 24'h1);
    check({20'h0, general_code_protect, gwp, seg_on, complete}, 24'h0);
    rcfg(2'h0, 24'hffffff);
    nvm(pg(7'h10), 1'b0, 4'h0);
  endtask : t_erase

  initial begin
    repeat (4) @(negedge sys_clk_in);
    rstn_in = 1'b1;
    @(negedge sys_clk_in);
    t_reset();
    t_open();
    t_cfg();
    t_segment();
    t_general();
    t_erase();
    stop_test();
  end

  // Whole run needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge sys_clk_in);
    fails++;
    stop_test();
  end
endmodule : flash_code_write_protection_tb
